// [hdl/adc_channel_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_channel_config_regs #(
  parameter int PULSE_CYCLES = adc_cfg_pkg::READY_PULSE_CYCLES
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  input  wire logic [3:0]             pstrb_i,
  output var  logic [31:0]            prdata_o,
  output var  logic                   pready_o,
  output var  logic                   pslverr_o,
  input  wire logic [3:0]             chan_result_i,
  input  wire logic [3:0]             result_taken_i,
  output var  logic                   result_ready_pin_o,
  output var  logic                   result_ready_pin_oe_n_o,
  output var  adc_cfg_pkg::chan_cfg_s chan_cfg_o,
  output var  adc_cfg_pkg::amp_cfg_s  amp_cfg_o,
  output var  logic                   irq_o
);

  logic [3:0]              mode_control;
  logic [15:0]             clock_channel_config;
  logic [15:0]             gain_select_low;
  logic [4:0]              irq_mask;
  logic [3:0]              next_mode_control;
  logic [15:0]             next_clock_channel_config;
  logic [15:0]             next_gain_select_low;
  logic [4:0]              next_irq_mask;
  logic [31:0]             next_prdata;
  logic                    next_pready;
  logic                    next_pslverr;
  logic                    setup;
  logic                    wr_take;
  logic                    hit_mode;
  logic                    hit_clock;
  logic                    hit_gain;
  logic                    hit_status;
  logic                    hit_mask;
  logic [15:0]             wdata;
  logic [4:0]              irq_clear;
  logic [4:0]              irq_events;
  logic [4:0]              irq_status;
  logic [3:0]              chan_on;
  logic [3:0]              chan_set;
  logic [3:0]              chan_flag;
  logic                    lead_flag;
  logic                    pending;
  logic                    pending_q;
  logic                    pending_rise;
  logic                    pulse_busy;
  logic                    pulse_start;
  adc_cfg_pkg::pin_state_e pin_state;
  adc_cfg_pkg::pin_state_e next_pin_state;
  logic                    next_pin;
  logic                    next_pin_oe_n;
  logic                    next_irq;
  adc_cfg_pkg::chan_cfg_s  next_chan_cfg;
  adc_cfg_pkg::amp_cfg_s   next_amp_cfg;
  adc_cfg_pkg::ready_src_e src_sel;

  // Bus decode
  always_comb begin
    setup      = psel_i && !penable_i;
    wr_take    = psel_i && penable_i && pready_o && pwrite_i && (paddr_i[1:0] == 2'b00);
    hit_mode   = paddr_i[11:2] == adc_cfg_pkg::MODE_IDX;
    hit_clock  = paddr_i[11:2] == adc_cfg_pkg::CLOCK_IDX;
    hit_gain   = paddr_i[11:2] == adc_cfg_pkg::GAIN_IDX;
    hit_status = paddr_i[11:2] == adc_cfg_pkg::IRQ_STATUS_IDX;
    hit_mask   = paddr_i[11:2] == adc_cfg_pkg::IRQ_MASK_IDX;
    wdata[7:0]  = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;
    wdata[15:8] = pstrb_i[1] ? pwdata_i[15:8] : 8'h00;
  end

  // Register writes
  always_comb begin
    next_mode_control         = mode_control;
    next_clock_channel_config = clock_channel_config;
    next_gain_select_low      = gain_select_low;
    next_irq_mask             = irq_mask;
    irq_clear                 = 5'h00;
    if (wr_take) begin
      if (hit_mode && pstrb_i[0]) begin
        next_mode_control = wdata[3:0];
      end
      if (hit_clock) begin
        // Reserved bits are not stored and read zero
        for (int b = 0; b < 2; b++) begin
          if (pstrb_i[b]) begin
            next_clock_channel_config[b*8 +: 8] = wdata[b*8 +: 8]
              & adc_cfg_pkg::CLOCK_WMASK[b*8 +: 8];
          end
        end
      end
      if (hit_gain) begin
        for (int b = 0; b < 2; b++) begin
          if (pstrb_i[b]) begin
            next_gain_select_low[b*8 +: 8] = wdata[b*8 +: 8]
              & adc_cfg_pkg::GAIN_WMASK[b*8 +: 8];
          end
        end
      end
      if (hit_mask && pstrb_i[0]) begin
        next_irq_mask = wdata[4:0];
      end
      if (hit_status && pstrb_i[0]) begin
        irq_clear = wdata[4:0];
      end
    end
  end

  // Read data and response, answered in the first access cycle
  always_comb begin
    next_pready  = setup;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (setup) begin
      if (paddr_i[1:0] != 2'b00) begin
        next_pslverr = 1'b1;
      end else if (hit_mode) begin
        next_prdata[3:0] = mode_control;
      end else if (hit_clock) begin
        next_prdata[15:0] = clock_channel_config;
      end else if (hit_gain) begin
        next_prdata[15:0] = gain_select_low;
      end else if (hit_status) begin
        next_prdata[4:0] = irq_status;
      end else if (hit_mask) begin
        next_prdata[4:0] = irq_mask;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  // Decoded configuration for the converter
  always_comb begin
    next_chan_cfg.chan_on =
      next_clock_channel_config[adc_cfg_pkg::CHAN_ON_LSB +: 4];
    next_chan_cfg.turbo_ratio_force =
      next_clock_channel_config[adc_cfg_pkg::TURBO_BIT];
    next_chan_cfg.oversample_ratio_code =
      next_clock_channel_config[adc_cfg_pkg::OSR_LSB +: 3];
    next_chan_cfg.power_level_code = adc_cfg_pkg::power_mode_e'(
      next_clock_channel_config[adc_cfg_pkg::PWR_LSB +: 2]);
    if (next_chan_cfg.turbo_ratio_force) begin
      next_chan_cfg.ratio = adc_cfg_pkg::TURBO_RATIO;
    end else begin
      next_chan_cfg.ratio = adc_cfg_pkg::OSR_BASE_RATIO
        << next_chan_cfg.oversample_ratio_code;
    end
    for (int c = 0; c < 4; c++) begin
      next_amp_cfg.code[c] =
        next_gain_select_low[c*adc_cfg_pkg::GAIN_STRIDE +: 3];
      next_amp_cfg.factor[c] =
        adc_cfg_pkg::UNITY_GAIN << next_amp_cfg.code[c];
    end
  end

  // Per-channel new-data flags, disabled channels excluded
  always_comb begin
    chan_on  = chan_cfg_o.chan_on;
    chan_set = chan_result_i & chan_on;
    src_sel  = adc_cfg_pkg::ready_src_e'(mode_control[adc_cfg_pkg::SEL_LSB +: 2]);
  end

  sticky_flag #(
    .W (4)
  ) chan_flags (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (chan_set),
    .clr_i     (result_taken_i | ~chan_on),
    .q_o       (chan_flag)
  );

  // Leading source latches on the first enabled arrival
  sticky_flag #(
    .W (1)
  ) lead_latch (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (|chan_set),
    .clr_i     (|result_taken_i),
    .q_o       (lead_flag)
  );

  always_comb begin
    case (src_sel)
      adc_cfg_pkg::SRC_LAGGING: begin
        pending = (|chan_on) && (&(chan_flag | ~chan_on));
      end
      adc_cfg_pkg::SRC_OR: begin
        pending = |(chan_flag & chan_on);
      end
      adc_cfg_pkg::SRC_LEAD, adc_cfg_pkg::SRC_LEAD_ALT: begin
        pending = lead_flag;
      end
      default: begin
        pending = 1'b0;
      end
    endcase
    pending_rise = pending && !pending_q;
  end

  // Ready pin sequencing
  always_comb begin
    next_pin_state = pin_state;
    pulse_start    = 1'b0;
    case (pin_state)
      adc_cfg_pkg::PIN_IDLE: begin
        if (pending_rise) begin
          if (mode_control[adc_cfg_pkg::FMT_BIT]) begin
            next_pin_state = adc_cfg_pkg::PIN_PULSE;
            pulse_start    = 1'b1;
          end else begin
            next_pin_state = adc_cfg_pkg::PIN_HELD;
          end
        end
      end
      adc_cfg_pkg::PIN_HELD: begin
        if (!pending) begin
          next_pin_state = adc_cfg_pkg::PIN_IDLE;
        end
      end
      adc_cfg_pkg::PIN_PULSE: begin
        if (!pulse_busy) begin
          next_pin_state = pending ? adc_cfg_pkg::PIN_WAIT : adc_cfg_pkg::PIN_IDLE;
        end
      end
      adc_cfg_pkg::PIN_WAIT: begin
        if (!pending) begin
          next_pin_state = adc_cfg_pkg::PIN_IDLE;
        end
      end
      default: begin
        next_pin_state = adc_cfg_pkg::PIN_IDLE;
      end
    endcase
    if (next_pin_state == adc_cfg_pkg::PIN_HELD ||
        next_pin_state == adc_cfg_pkg::PIN_PULSE) begin
      next_pin      = 1'b0;
      next_pin_oe_n = 1'b0;
    end else begin
      next_pin      = 1'b1;
      next_pin_oe_n = mode_control[adc_cfg_pkg::FLOAT_BIT];
    end
  end

  pulse_timer #(
    .CYCLES (PULSE_CYCLES),
    .W      (8)
  ) ready_pulse (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .start_i   (pulse_start),
    .busy_o    (pulse_busy)
  );

  // Interrupt events: enabled channel arrivals and the rise of the ready pending condition
  always_comb begin
    irq_events                                = 5'h00;
    irq_events[3:0]                           = chan_set;
    irq_events[adc_cfg_pkg::READY_EVENT_BIT] = pending_rise;
    next_irq                                  = |(irq_status & irq_mask);
  end

  sticky_flag #(
    .W (5)
  ) irq_flags (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (irq_events),
    .clr_i     (irq_clear),
    .q_o       (irq_status)
  );

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_control            <= adc_cfg_pkg::MODE_RESET;
      clock_channel_config    <= adc_cfg_pkg::CLOCK_RESET;
      gain_select_low         <= adc_cfg_pkg::GAIN_RESET;
      irq_mask                <= adc_cfg_pkg::IRQ_MASK_RESET;
      prdata_o                <= 32'h0000_0000;
      pready_o                <= 1'b0;
      pslverr_o               <= 1'b0;
      pending_q               <= 1'b0;
      pin_state               <= adc_cfg_pkg::PIN_IDLE;
      result_ready_pin_o      <= 1'b1;
      result_ready_pin_oe_n_o <= 1'b0;
      chan_cfg_o              <= '{chan_on: 4'hF, turbo_ratio_force: 1'b0,
                                   oversample_ratio_code: 3'h3,
                                   power_level_code: adc_cfg_pkg::PWR_HR,
                                   ratio: 15'h0400};
      amp_cfg_o               <= '{code: '0, factor: {4{adc_cfg_pkg::UNITY_GAIN}}};
      irq_o                   <= 1'b0;
    end else begin
      mode_control            <= next_mode_control;
      clock_channel_config    <= next_clock_channel_config;
      gain_select_low         <= next_gain_select_low;
      irq_mask                <= next_irq_mask;
      prdata_o                <= next_prdata;
      pready_o                <= next_pready;
      pslverr_o               <= next_pslverr;
      pending_q               <= pending;
      pin_state               <= next_pin_state;
      result_ready_pin_o      <= next_pin;
      result_ready_pin_oe_n_o <= next_pin_oe_n;
      chan_cfg_o              <= next_chan_cfg;
      amp_cfg_o               <= next_amp_cfg;
      irq_o                   <= next_irq;
    end
  end

endmodule
`default_nettype wire

// [hdl/adc_cfg_pkg.sv]
`default_nettype none
package adc_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  MODE_IDX          = 10'h002;
  localparam logic [9:0]  CLOCK_IDX         = 10'h003;
  localparam logic [9:0]  GAIN_IDX          = 10'h004;
  localparam logic [9:0]  IRQ_STATUS_IDX    = 10'h008;
  localparam logic [9:0]  IRQ_MASK_IDX      = 10'h009;

  // Values after reset
  localparam logic [3:0]  MODE_RESET        = 4'h0;
  localparam logic [15:0] CLOCK_RESET       = 16'h0F0E;
  localparam logic [15:0] GAIN_RESET        = 16'h0000;
  localparam logic [4:0]  IRQ_MASK_RESET    = 5'h00;

  // Writable bits; everything else reads zero
  localparam logic [15:0] CLOCK_WMASK       = 16'h0F3F;
  localparam logic [15:0] GAIN_WMASK        = 16'h7777;

  // Field positions
  localparam int          FMT_BIT           = 0;
  localparam int          FLOAT_BIT         = 1;
  localparam int          SEL_LSB           = 2;
  localparam int          PWR_LSB           = 0;
  localparam int          OSR_LSB           = 2;
  localparam int          TURBO_BIT         = 5;
  localparam int          CHAN_ON_LSB       = 8;
  localparam int          GAIN_STRIDE       = 4;
  localparam int          READY_EVENT_BIT   = 4;

  // Ratio decoding
  localparam logic [14:0] OSR_BASE_RATIO    = 15'h0080;
  localparam logic [14:0] TURBO_RATIO       = 15'h0040;
  localparam logic [7:0]  UNITY_GAIN        = 8'h01;

  // Timing of the fixed ready pulse
  localparam int          CLK_PERIOD_PS     = 4000;
  localparam int          READY_PULSE_NS    = 16;
  localparam int          READY_PULSE_CYCLES =
    (READY_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    SRC_LAGGING  = 2'b00,
    SRC_OR       = 2'b01,
    SRC_LEAD     = 2'b10,
    SRC_LEAD_ALT = 2'b11
  } ready_src_e;

  typedef enum logic [1:0] {
    PWR_VLP    = 2'b00,
    PWR_LP     = 2'b01,
    PWR_HR     = 2'b10,
    PWR_HR_ALT = 2'b11
  } power_mode_e;

  typedef enum logic [1:0] {
    PIN_IDLE  = 2'b00,
    PIN_HELD  = 2'b01,
    PIN_PULSE = 2'b10,
    PIN_WAIT  = 2'b11
  } pin_state_e;

  typedef struct packed {
    logic [3:0]  chan_on;
    logic        turbo_ratio_force;
    logic [2:0]  oversample_ratio_code;
    power_mode_e power_level_code;
    logic [14:0] ratio;
  } chan_cfg_s;

  typedef struct packed {
    logic [3:0][2:0] code;
    logic [3:0][7:0] factor;
  } amp_cfg_s;

endpackage
`default_nettype wire

// [hdl/sticky_flag.sv]
`timescale 1ns/1ps
`default_nettype none
module sticky_flag #(
  parameter int W = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] next_q;

  // Set wins over a clear in the same cycle
  always_comb begin
    next_q = set_i | (q_o & ~clr_i);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_o <= '0;
    end else begin
      q_o <= next_q;
    end
  end

endmodule
`default_nettype wire

// [hdl/pulse_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
  parameter int CYCLES = 4,
  parameter int W      = 8
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  output var  logic busy_o
);

  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_busy;

  // Busy for CYCLES-1 cycles after start, so a state entered with start lasts CYCLES
  always_comb begin
    next_count = count;
    next_busy  = busy_o;
    if (start_i) begin
      next_count = W'(1);
      next_busy  = (CYCLES > 1);
    end else if (busy_o) begin
      if (count == LAST) begin
        next_busy = 1'b0;
      end else begin
        next_count = count + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count  <= '0;
      busy_o <= 1'b0;
    end else begin
      count  <= next_count;
      busy_o <= next_busy;
    end
  end

endmodule
`default_nettype wire

// [test/adc_channel_config_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_checker #(
  parameter int PULSE_CYCLES = 4
) (
  input wire logic                   clk_sys_i,
  input wire logic                   resetn_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [11:0]            paddr_i,
  input wire logic [31:0]            pwdata_i,
  input wire logic [3:0]             pstrb_i,
  input wire logic [31:0]            prdata_o,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  input wire logic [3:0]             chan_result_i,
  input wire logic [3:0]             result_taken_i,
  input wire logic                   result_ready_pin_o,
  input wire logic                   result_ready_pin_oe_n_o,
  input wire adc_cfg_pkg::chan_cfg_s chan_cfg_o,
  input wire adc_cfg_pkg::amp_cfg_s  amp_cfg_o,
  input wire logic                   irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic wr_go;
  assign wr_go = psel_i && penable_i && pready_o && pwrite_i;

  a_reset_values: assert property (
    $rose(resetn_i) |-> chan_cfg_o.chan_on == 4'hF && chan_cfg_o.power_level_code == 2'h2
    && chan_cfg_o.oversample_ratio_code == 3'h3 && amp_cfg_o.code == 12'h000)
    else $error("reset values wrong");
  a_turbo_ratio: assert property (
    chan_cfg_o.turbo_ratio_force |-> chan_cfg_o.ratio == 15'h0040)
    else $error("turbo ratio wrong");
  a_osr_ratio: assert property (
    !chan_cfg_o.turbo_ratio_force
    |-> chan_cfg_o.ratio == 15'h0080 << chan_cfg_o.oversample_ratio_code)
    else $error("ratio decode wrong");
  a_gain_factor: assert property (
    amp_cfg_o.factor[3] == 8'h01 << amp_cfg_o.code[3]
    && amp_cfg_o.factor[0] == 8'h01 << amp_cfg_o.code[0])
    else $error("gain factor wrong");
  a_chan_write: assert property (
    wr_go && paddr_i == 12'h00C && pstrb_i[1]
    |=> ##1 chan_cfg_o.chan_on == $past(pwdata_i[11:8], 2))
    else $error("channel enables not written");
  a_power_write: assert property (
    wr_go && paddr_i == 12'h00C && pstrb_i[0]
    |=> ##1 chan_cfg_o.power_level_code == $past(pwdata_i[1:0], 2))
    else $error("power code not written");
  a_gain_place: assert property (
    wr_go && paddr_i == 12'h010 && pstrb_i[1] |=> ##1
    amp_cfg_o.code[3] == $past(pwdata_i[14:12], 2) && amp_cfg_o.code[2] == $past(pwdata_i[10:8], 2))
    else $error("gain fields misplaced");
  a_low_driven: assert property (
    !result_ready_pin_o |-> !result_ready_pin_oe_n_o)
    else $error("ready low while floating");
  a_reserved_zero: assert property (
    pready_o && !pwrite_i && paddr_i == 12'h00C |-> prdata_o[15:12] == 4'h0 && prdata_o[7:6] == 2'h0)
    else $error("reserved bits not zero");
  a_apb_answer: assert property (
    psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("bus answer timing wrong");

  c_turbo: cover property (chan_cfg_o.turbo_ratio_force);
  c_pin_low: cover property ($fell(result_ready_pin_o));
  c_unmapped: cover property (pready_o && pslverr_o);
endmodule

bind adc_channel_config_regs adc_cfg_checker #(.PULSE_CYCLES(PULSE_CYCLES))
  adc_cfg_checker_inst (
  .clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
  .prdata_o, .pready_o, .pslverr_o, .chan_result_i, .result_taken_i, .result_ready_pin_o,
  .result_ready_pin_oe_n_o, .chan_cfg_o, .amp_cfg_o, .irq_o);
`default_nettype wire

// [test/conv_channels.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_channels (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic       start_i,
  input  wire logic       take_i,
  output var  logic [3:0] chan_result_o,
  output var  logic [3:0] result_taken_o
);
  logic [4:0] phase;
  logic [4:0] next_phase;
  logic [3:0] next_taken;
  // Channel 0 leads, each next channel lags one cycle more
  always_comb begin
    next_phase = start_i ? 5'h01 : {phase[3:0], 1'b0};
    next_taken = take_i ? 4'hF : 4'h0;
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase <= 5'h00;
      result_taken_o <= 4'h0;
    end else begin
      phase <= next_phase;
      result_taken_o <= next_taken;
    end
  end
  assign chan_result_o = phase[3:0];
endmodule
`default_nettype wire

// [test/adc_channel_config_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_channel_config_regs_test;
  localparam int PC = 3;
  localparam logic [11:0] ADDR_MODE  = {adc_cfg_pkg::MODE_IDX, 2'b00};
  localparam logic [11:0] ADDR_CLOCK = {adc_cfg_pkg::CLOCK_IDX, 2'b00};
  localparam logic [11:0] ADDR_GAIN  = {adc_cfg_pkg::GAIN_IDX, 2'b00};
  logic clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, start, take;
  logic result_ready_pin_o, result_ready_pin_oe_n_o, irq_o, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic [3:0]  pstrb_i, chan_res, taken, m;
  logic [11:0] tab [7] = '{12'h4F3, 12'h0F6, 12'h075, 12'h8F3, 12'hCE4, 12'h7F3, 12'h3B6};
  adc_cfg_pkg::chan_cfg_s chan_cfg_o;
  adc_cfg_pkg::amp_cfg_s  amp_cfg_o;
  int n_errors = 0;
  int num_checks = 0;
  int i, d, lo;

  adc_channel_config_regs #(.PULSE_CYCLES(PC)) adc_channel_config_regs_inst (
    .clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .chan_result_i(chan_res), .result_taken_i(taken),
    .result_ready_pin_o, .result_ready_pin_oe_n_o, .chan_cfg_o, .amp_cfg_o, .irq_o);
  conv_channels conv_channels_inst (.clk_sys_i, .resetn_i, .start_i(start), .take_i(take),
    .chan_result_o(chan_res), .result_taken_o(taken));

  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    n_errors++;
    $display("Error at %0t: timeout", $time);
    final_report;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) hang;
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] wd);
    apb(1'b1, a, {16'h0000, wd});
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, {16'h0000, exp});
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic run(output int dl, output int low);
    @(posedge clk_sys_i);
    start <= 1'b1;
    @(posedge clk_sys_i);
    start <= 1'b0;
    #1;
    dl = 1;
    low = 0;
    while (result_ready_pin_o !== 1'b0 && dl < 20) begin
      @(posedge clk_sys_i);
      #1;
      dl++;
    end
    while (result_ready_pin_o === 1'b0 && low < 12) begin
      @(posedge clk_sys_i);
      #1;
      low++;
    end
    @(posedge clk_sys_i);
    take <= 1'b1;
    @(posedge clk_sys_i);
    take <= 1'b0;
    for (int k = 0; result_ready_pin_o !== 1'b1; k++) begin
      if (k == 20) hang;
      @(posedge clk_sys_i);
    end
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    resetn_i = 1'b0;
    {psel_i, penable_i, pwrite_i, start, take} = 5'h00;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'h3;
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(ADDR_CLOCK, 16'h0F0E);
    rd(ADDR_GAIN, 16'h0000);
    rd(ADDR_MODE, 16'h0000);
    apb(1'b0, 12'h014, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h00E, 32'h0);
    chk({31'h0, err}, 32'h1);
    rd(ADDR_CLOCK, 16'h0F0E);
    for (i = 0; i < 8; i++) begin
      wr(ADDR_CLOCK, 16'h0F00 | (i << 2) | (i & 3));
      settle;
      chk(chan_cfg_o.ratio, 32'h80 << i);
      chk(chan_cfg_o.power_level_code, i & 3);
      rd(ADDR_CLOCK, 16'h0F00 | (i << 2) | (i & 3));
    end
    wr(ADDR_CLOCK, 16'h0A35);
    settle;
    chk(chan_cfg_o.ratio, 32'h40);
    chk(chan_cfg_o.chan_on, 4'hA);
    for (i = 0; i < 8; i++) begin
      wr(ADDR_GAIN, {4{1'b0, i[2:0]}});
      settle;
      chk(amp_cfg_o.factor[3], 32'h1 << i);
      chk(amp_cfg_o.code[2], i[2:0]);
      rd(ADDR_GAIN, {4{1'b0, i[2:0]}});
    end
    for (i = 0; i < 7; i++) begin
      m = tab[i][11:8];
      wr(ADDR_CLOCK, {4'h0, tab[i][7:4], 8'h0E});
      wr(ADDR_MODE, {12'h000, m});
      settle;
      chk(result_ready_pin_oe_n_o, m[1]);
      if (!m[1]) chk(result_ready_pin_o, 1'b1);
      run(d, lo);
      chk(d, tab[i][3:0]);
      chk(lo, m[0] ? PC : 12);
    end
    chk(irq_o, 1'b0);
    rd(12'h020, 16'h001F);
    wr(12'h024, 16'h0010);
    settle;
    chk(irq_o, 1'b1);
    wr(12'h020, 16'h001F);
    settle;
    chk(irq_o, 1'b0);
    rd(12'h020, 16'h0000);
    final_report;
  end
endmodule
`default_nettype wire
